// [logic/peer_share_params.svh]
/*
 * constants of the sharing engine: indices, fields, resets, timing.
 * assumes inclusion by bare name.
 */
`ifndef PEER_SHARE_PARAMS_SVH
`define PEER_SHARE_PARAMS_SVH

// ============================================================================
// register indices; byte address = 4 * index
`define IDX_TX_PACKET_COUNT_A    13'd2064
`define IDX_TX_PACKET_COUNT_B    13'd2065
`define IDX_COLLISION_COUNT_A    13'd2066
`define IDX_COLLISION_COUNT_B    13'd2067
`define IDX_PEER_ACTIVE_BITMAP   13'd3303
`define IDX_UPDATE_INTERVAL_MS   13'd8011
`define IDX_OWN_NODE_NUMBER      13'd8012
`define IDX_TX_SOURCE_START      13'd8013
`define IDX_NODE_TOTAL_COUNT     13'd8026
`define IDX_TX_REGISTER_COUNT    13'd8027
`define IDX_RX_DESTINATION_START 13'd8028
`define IDX_MODULE_CONTROL_FLAGS 13'd8030
// mailbox registers 1..512 at indices 1..512
`define MBX_DEPTH                13'd512
`define MBX_AW                   9

// ============================================================================
// fields and reset values
`define SHARE_ENABLE_BIT         5
`define RST_UPDATE_INTERVAL      16'h0018
`define RST_NODE_TOTAL           16'h0001
`define RST_TX_COUNT             16'h0001
`define RST_START_REG            16'h0001
`define MAX_TX_COUNT             16'h0080
`define ACTIVE_NODES             16
`define HDR_WORDS                8'h03

// ============================================================================
// timing
`define CLK_HZ                   10000000
`define MS_PER_S                 1000
`define CYCLES_PER_MS            (`CLK_HZ / `MS_PER_S)

`endif

// [logic/peer_share_pkg.sv]
/*
 * types of the peer register sharing engine.
 * assumes nothing of its surroundings.
 */
`default_nettype none

package peer_share_pkg;
    // ========================================================================
    // transmit sequencer states
    typedef enum logic [0:0] {
        TX_IDLE,
        TX_SEND
    } tx_state_type;
endpackage

`default_nettype wire

// [logic/peer_share.sv]
/*
 * peer register sharing engine: sends a mailbox slice in its slot,
 * copies received slices to the mailbox, tracks live peers,
 * counts frames and collisions; apb register access.
 * assumes a mac on ref_clk with word streams and collision pulses.
 */
// Contract
// - one multicast frame per update
// - counts 1 to 128 may be sent
// - slot node number is not the drop number
// - node total count divides the interval into slots
// - slice source start from its register
// - count per frame from its register
// - peer destination start carried from its register
// - update interval register counts milliseconds
// - control bit five, value 32, enables sharing
// - active flags set when heard, clear on silence
// - nodes 17 and above have no active flag
// - a lost peer only clears its flag
// - two readable collision counters
// - two readable packet counters
// - no reply frame sent or awaited
// - broadcast falls inside this node's own slot
// - broadcasts take precedence over other traffic
// - node number zero listens only
// - sharing off ignores peer frames
// - interval spans two sends of one node
`timescale 1ns/10ps
`default_nettype none
`include "peer_share_params.svh"

module peer_share #(
    parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // multicast frame stream to the mac
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic      [15:0] tx_data,
    output logic             tx_first,
    output logic             tx_last,
    // peer frame stream from the mac
    input  wire logic        rx_valid,
    input  wire logic [15:0] rx_data,
    input  wire logic        rx_first,
    input  wire logic        rx_last,
    // mac statistics events
    input  wire logic        mac_collision,
    input  wire logic        mac_excess_collision,
    // other module traffic arbitration
    input  wire logic        other_req,
    output logic             other_grant
);

    // ========================================================================
    // storage
    logic [15:0] mailbox [0:`MBX_DEPTH-1];
    logic [15:0] interval_q, interval_d;
    logic [15:0] own_node_q, own_node_d;
    logic [15:0] src_start_q, src_start_d;
    logic [15:0] node_total_q, node_total_d;
    logic [15:0] tx_count_q, tx_count_d;
    logic [15:0] dst_start_q, dst_start_d;
    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] tx_pkt_q, tx_pkt_d;
    logic [15:0] rx_pkt_q, rx_pkt_d;
    logic [15:0] coll_q, coll_d;
    logic [15:0] xcoll_q, xcoll_d;
    logic [31:0] prdata_q, prdata_d;
    logic        share_en;
    logic [12:0] idx;
    logic        apb_wr;
    logic        mapped;
    logic        is_mbx;

    assign share_en = ctrl_q[`SHARE_ENABLE_BIT];
    assign idx      = paddr[14:2];
    assign is_mbx   = (idx != 13'h0000) && (idx <= `MBX_DEPTH);
    assign apb_wr   = psel && penable && pwrite;
    assign pready   = 1'b1;
    assign prdata   = prdata_q;

    // ========================================================================
    // apb decode; read data taken in the setup cycle
    always_comb begin
        case (idx)
            `IDX_TX_PACKET_COUNT_A, `IDX_TX_PACKET_COUNT_B,
            `IDX_COLLISION_COUNT_A, `IDX_COLLISION_COUNT_B,
            `IDX_PEER_ACTIVE_BITMAP, `IDX_UPDATE_INTERVAL_MS,
            `IDX_OWN_NODE_NUMBER, `IDX_TX_SOURCE_START,
            `IDX_NODE_TOTAL_COUNT, `IDX_TX_REGISTER_COUNT,
            `IDX_RX_DESTINATION_START, `IDX_MODULE_CONTROL_FLAGS:
                mapped = 1'b1;
            default:
                mapped = is_mbx;
        endcase
    end

    assign pslverr = psel && penable && (!mapped || paddr[15]
                     || paddr[1:0] != 2'b00);

    logic [15:0] active_q;
    logic [15:0] rd_word;

    always_comb begin
        case (idx)
            `IDX_TX_PACKET_COUNT_A:    rd_word = tx_pkt_q;
            `IDX_TX_PACKET_COUNT_B:    rd_word = rx_pkt_q;
            `IDX_COLLISION_COUNT_A:    rd_word = coll_q;
            `IDX_COLLISION_COUNT_B:    rd_word = xcoll_q;
            `IDX_PEER_ACTIVE_BITMAP:   rd_word = active_q;
            `IDX_UPDATE_INTERVAL_MS:   rd_word = interval_q;
            `IDX_OWN_NODE_NUMBER:      rd_word = own_node_q;
            `IDX_TX_SOURCE_START:      rd_word = src_start_q;
            `IDX_NODE_TOTAL_COUNT:     rd_word = node_total_q;
            `IDX_TX_REGISTER_COUNT:    rd_word = tx_count_q;
            `IDX_RX_DESTINATION_START: rd_word = dst_start_q;
            `IDX_MODULE_CONTROL_FLAGS: rd_word = ctrl_q;
            default: begin
                if (is_mbx) begin
                    rd_word = mailbox[idx[`MBX_AW-1:0] - 9'h001];
                end else begin
                    rd_word = 16'h0000;
                end
            end
        endcase
        prdata_d = prdata_q;
        if (psel && !penable && !pwrite) begin
            prdata_d = (!mapped || paddr[15] || paddr[1:0] != 2'b00)
                       ? 32'h0000_0000 : {16'h0000, rd_word};
        end
    end

    // ========================================================================
    // software written configuration
    always_comb begin
        interval_d   = interval_q;
        own_node_d   = own_node_q;
        src_start_d  = src_start_q;
        node_total_d = node_total_q;
        tx_count_d   = tx_count_q;
        dst_start_d  = dst_start_q;
        ctrl_d       = ctrl_q;
        if (apb_wr && !pslverr) begin
            case (idx)
                `IDX_UPDATE_INTERVAL_MS:   interval_d   = pwdata[15:0];
                `IDX_OWN_NODE_NUMBER:      own_node_d   = pwdata[15:0];
                `IDX_TX_SOURCE_START:      src_start_d  = pwdata[15:0];
                `IDX_NODE_TOTAL_COUNT:     node_total_d = pwdata[15:0];
                `IDX_TX_REGISTER_COUNT:    tx_count_d   = pwdata[15:0];
                `IDX_RX_DESTINATION_START: dst_start_d  = pwdata[15:0];
                `IDX_MODULE_CONTROL_FLAGS: ctrl_d       = pwdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            interval_q   <= `RST_UPDATE_INTERVAL;
            own_node_q   <= 16'h0000;
            src_start_q  <= `RST_START_REG;
            node_total_q <= `RST_NODE_TOTAL;
            tx_count_q   <= `RST_TX_COUNT;
            dst_start_q  <= `RST_START_REG;
            ctrl_q       <= 16'h0000;
            prdata_q     <= 32'h0000_0000;
        end else begin
            interval_q   <= interval_d;
            own_node_q   <= own_node_d;
            src_start_q  <= src_start_d;
            node_total_q <= node_total_d;
            tx_count_q   <= tx_count_d;
            dst_start_q  <= dst_start_d;
            ctrl_q       <= ctrl_d;
            prdata_q     <= prdata_d;
        end
    end

    // ========================================================================
    // millisecond tick and interval position
    logic [15:0] div_q, div_d;
    logic [15:0] ms_pos_q, ms_pos_d;
    logic        ms_tick;
    logic        slot_done_q, slot_done_d;
    logic [31:0] pos_prod;
    logic [31:0] slot_prod;
    logic        can_send;
    logic        fire;

    assign ms_tick  = (div_q == 16'(CYCLES_PER_MS - 1));
    // node n sends once pos * total reaches (n-1) * interval
    assign pos_prod  = ms_pos_q * node_total_q;
    assign slot_prod = (own_node_q - 16'h0001) * interval_q;
    // node 0 listens only; counts outside 1..128 send nothing
    assign can_send = share_en && (own_node_q != 16'h0000)
                      && (tx_count_q != 16'h0000)
                      && (tx_count_q <= `MAX_TX_COUNT)
                      && (node_total_q != 16'h0000)
                      && (interval_q != 16'h0000);
    assign fire = can_send && !slot_done_q
                  && (pos_prod >= slot_prod);

    always_comb begin
        div_d       = ms_tick ? 16'h0000 : div_q + 16'h0001;
        ms_pos_d    = ms_pos_q;
        slot_done_d = slot_done_q || fire;
        if (!share_en) begin
            ms_pos_d    = 16'h0000;
            slot_done_d = 1'b0;
        end else if (ms_tick) begin
            // one send per interval
            if (ms_pos_q + 16'h0001 >= interval_q) begin
                ms_pos_d    = 16'h0000;
                slot_done_d = 1'b0;
            end else begin
                ms_pos_d = ms_pos_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            div_q       <= 16'h0000;
            ms_pos_q    <= 16'h0000;
            slot_done_q <= 1'b0;
        end else begin
            div_q       <= div_d;
            ms_pos_q    <= ms_pos_d;
            slot_done_q <= slot_done_d;
        end
    end

    // ========================================================================
    // transmit: header words then the slice
    peer_share_pkg::tx_state_type tx_state_q, tx_state_d;
    logic [7:0]  word_q, word_d;
    logic [15:0] txd_q, txd_d;
    logic [7:0]  last_word;
    logic        pending_q, pending_d;
    logic        tx_hs;

    assign last_word = 8'(tx_count_q) + `HDR_WORDS - 8'h01;
    assign tx_hs     = tx_valid && tx_ready;
    assign tx_valid  = (tx_state_q == peer_share_pkg::TX_SEND);
    assign tx_data   = txd_q;
    assign tx_first  = tx_valid && (word_q == 8'h00);
    assign tx_last   = tx_valid && (word_q == last_word);
    // other traffic waits while a broadcast is pending or in flight
    assign other_grant = other_req && !pending_q && !tx_valid;

    // word i of the frame
    function automatic logic [15:0] frame_word(input logic [7:0] i);
        logic [15:0] reg_no;
        reg_no = src_start_q + 16'(i) - 16'(`HDR_WORDS);
        case (i)
            8'h00:   frame_word = own_node_q;
            8'h01:   frame_word = dst_start_q;
            8'h02:   frame_word = tx_count_q;
            default: frame_word = mailbox[reg_no[`MBX_AW-1:0] - 9'h001];
        endcase
    endfunction

    always_comb begin
        tx_state_d = tx_state_q;
        word_d     = word_q;
        txd_d      = txd_q;
        pending_d  = pending_q || fire;
        case (tx_state_q)
            peer_share_pkg::TX_IDLE: begin
                if (pending_q && can_send) begin
                    tx_state_d = peer_share_pkg::TX_SEND;
                    word_d     = 8'h00;
                    txd_d      = frame_word(8'h00);
                    pending_d  = fire;
                end else if (!can_send) begin
                    pending_d = 1'b0;
                end
            end
            peer_share_pkg::TX_SEND: begin
                if (tx_hs) begin
                    // no reply awaited
                    if (word_q == last_word) begin
                        tx_state_d = peer_share_pkg::TX_IDLE;
                    end else begin
                        word_d = word_q + 8'h01;
                        txd_d  = frame_word(word_q + 8'h01);
                    end
                end
            end
            default: tx_state_d = peer_share_pkg::TX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tx_state_q <= peer_share_pkg::TX_IDLE;
            word_q     <= 8'h00;
            txd_q      <= 16'h0000;
            pending_q  <= 1'b0;
        end else begin
            tx_state_q <= tx_state_d;
            word_q     <= word_d;
            txd_q      <= txd_d;
            pending_q  <= pending_d;
        end
    end

    // ========================================================================
    // receive: header, then slice into the mailbox
    logic [7:0]  rx_pos_q, rx_pos_d;
    logic [15:0] rx_src_q, rx_src_d;
    logic [15:0] rx_dst_q, rx_dst_d;
    logic [15:0] rx_cnt_q, rx_cnt_d;
    logic [7:0]  rx_pos;
    logic        rx_take;
    logic        rx_mbx_we;
    logic [15:0] rx_reg_no;
    logic        rx_done;
    logic [15:0] heard;

    // frames dropped while sharing is off
    assign rx_take   = rx_valid && share_en;
    assign rx_pos    = rx_first ? 8'h00 : rx_pos_q;
    assign rx_reg_no = rx_dst_q + 16'(rx_pos) - 16'(`HDR_WORDS);
    assign rx_mbx_we = rx_take && (rx_pos >= `HDR_WORDS)
                       && (16'(rx_pos) < rx_cnt_q + 16'(`HDR_WORDS))
                       && (rx_reg_no != 16'h0000)
                       && (rx_reg_no <= 16'(`MBX_DEPTH));
    assign rx_done   = rx_take && rx_last && (rx_pos >= `HDR_WORDS);

    always_comb begin
        rx_pos_d = rx_pos_q;
        rx_src_d = rx_src_q;
        rx_dst_d = rx_dst_q;
        rx_cnt_d = rx_cnt_q;
        if (rx_take) begin
            rx_pos_d = rx_last ? 8'h00 : rx_pos + 8'h01;
            case (rx_pos)
                8'h00:   rx_src_d = rx_data;
                8'h01:   rx_dst_d = rx_data;
                8'h02:   rx_cnt_d = rx_data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rx_pos_q <= 8'h00;
            rx_src_q <= 16'h0000;
            rx_dst_q <= 16'h0000;
            rx_cnt_q <= 16'h0000;
        end else begin
            rx_pos_q <= rx_pos_d;
            rx_src_q <= rx_src_d;
            rx_dst_q <= rx_dst_d;
            rx_cnt_q <= rx_cnt_d;
        end
    end

    // mailbox: a received word wins over a same-cycle write
    always_ff @(posedge ref_clk) begin
        if (rx_mbx_we) begin
            mailbox[rx_reg_no[`MBX_AW-1:0] - 9'h001] <= rx_data;
        end else if (apb_wr && is_mbx && !pslverr) begin
            mailbox[idx[`MBX_AW-1:0] - 9'h001] <= pwdata[15:0];
        end
    end

    // ========================================================================
    // liveness: heard sets a flag, two silent intervals
    // clear it; own timing ignores them
    genvar n;
    generate
        for (n = 0; n < `ACTIVE_NODES; n = n + 1) begin : g_node
            logic [16:0] age_q, age_d;
            logic        act_d;
            // only nodes 1..16 map to a flag
            assign heard[n] = rx_done && (rx_src_q == 16'(n + 1));
            always_comb begin
                age_d = age_q;
                act_d = active_q[n];
                if (!share_en) begin
                    age_d = 17'h00000;
                    act_d = 1'b0;
                end else if (heard[n]) begin
                    age_d = 17'h00000;
                    act_d = 1'b1;
                end else if (ms_tick && active_q[n]) begin
                    age_d = age_q + 17'h00001;
                    if (age_q >= {interval_q, 1'b0}) begin
                        act_d = 1'b0;
                    end
                end
            end
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    age_q       <= 17'h00000;
                    active_q[n] <= 1'b0;
                end else begin
                    age_q       <= age_d;
                    active_q[n] <= act_d;
                end
            end
        end
    endgenerate

    // ========================================================================
    // statistics counters
    always_comb begin
        tx_pkt_d = tx_pkt_q + 16'(tx_hs && tx_last);
        rx_pkt_d = rx_pkt_q + 16'(rx_done);
        coll_d   = coll_q + 16'(mac_collision);
        xcoll_d  = xcoll_q + 16'(mac_excess_collision);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tx_pkt_q <= 16'h0000;
            rx_pkt_q <= 16'h0000;
            coll_q   <= 16'h0000;
            xcoll_q  <= 16'h0000;
        end else begin
            tx_pkt_q <= tx_pkt_d;
            rx_pkt_q <= rx_pkt_d;
            coll_q   <= coll_d;
            xcoll_q  <= xcoll_d;
        end
    end

endmodule

`default_nettype wire

// [tb/peer_share_asserts.sv]
/*
 * checker of the peer sharing engine, bound to its top module.
 * assumes ref_clk is the only clock and sys_rst is synchronous.
 */
`timescale 1ns/10ps
`default_nettype none

module peer_share_asserts (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // frame stream and arbitration
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [15:0] tx_data,
    input wire logic        tx_first,
    input wire logic        tx_last,
    input wire logic        other_req,
    input wire logic        other_grant
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // ========================================================================
    // frame stream
    word_hold_a: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data)) else $error("word changed");
    first_valid_a: assert property (tx_first |-> tx_valid)
        else $error("stray first");
    last_valid_a: assert property (tx_last |-> tx_valid && !tx_first)
        else $error("stray last");
    frame_end_a: assert property (tx_valid && tx_ready && tx_last |=>
        !tx_valid) else $error("valid after last");
    first_once_a: assert property (tx_valid && tx_ready && tx_first |=>
        !tx_first) else $error("first repeated");

    // ========================================================================
    // arbitration and register bus
    grant_hold_a: assert property (other_grant |->
        !tx_valid && other_req) else $error("grant while sending");
    grant_back_a: assert property (tx_valid && tx_ready && tx_last &&
        other_req |=> other_grant) else $error("grant not returned");
    bad_addr_a: assert property (psel && penable && paddr[15] |->
        pslverr) else $error("no error");
    bad_read_a: assert property (psel && penable && !pwrite &&
        paddr[15] |-> prdata == 32'h0000_0000) else $error("bad read data");

    // main scenarios
    cover property (tx_valid && tx_ready && tx_last);
    cover property (psel && penable && pslverr);
    cover property (other_req && !other_grant);
endmodule

bind peer_share peer_share_asserts chk (
    .ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
    .tx_valid, .tx_ready, .tx_data, .tx_first, .tx_last, .other_req,
    .other_grant
);

`default_nettype wire

// [tb/peer_mac_model.sv]
/*
 * far side of the sharing engine: a mac that takes frames with stalls
 * and plays peer frames in. assumes the engine's ref_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module peer_mac_model (
    // clock
    input  wire logic        ref_clk,
    // frames from the engine
    input  wire logic        tx_valid,
    output logic             tx_ready,
    input  wire logic [15:0] tx_data,
    input  wire logic        tx_first,
    // frames to the engine
    output logic             rx_valid,
    output logic      [15:0] rx_data,
    output logic             rx_first,
    output logic             rx_last
);
    logic [15:0] got[$];
    int          starts[$];
    int          cyc;

    // ========================================================================
    // idle lines at start
    initial begin
        {tx_ready, rx_valid, rx_first, rx_last} = 4'h0;
        rx_data = 16'h0000;
        cyc = 0;
    end
    // take words on alternate cycles, note frame starts, never reply
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        tx_ready <= ~tx_ready;
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
            if (tx_first) starts.push_back(cyc);
        end
    end
    // one word a cycle; idle data shows the inverse
    task automatic send(input logic [15:0] w[$]);
        foreach (w[i]) begin
            @(posedge ref_clk);
            rx_valid <= 1'b1;
            rx_data <= w[i];
            rx_first <= (i == 0);
            rx_last <= (i == w.size() - 1);
        end
        @(posedge ref_clk);
        {rx_valid, rx_first, rx_last} <= 3'h0;
        rx_data <= ~w[w.size() - 1];
    endtask
endmodule

`default_nettype wire

// [tb/tb_peer_share.sv]
/*
 * testbench of the sharing engine: apb tasks and frame checks.
 * assumes the mac model beside it and a ten cycle millisecond.
 */
`timescale 1ns/10ps
`default_nettype none
`include "peer_share_params.svh"

`define CHK(what, exp, seen) begin \
    comparisons++; \
    if ((seen) !== (exp)) begin \
        n_errors++; \
        $display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen); \
    end \
end

module tb_peer_share;
    logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic        tx_valid, tx_ready, tx_first, tx_last, rx_valid, rx_first;
    logic        rx_last, mac_collision, mac_excess_collision, other_req;
    logic        other_grant, err;
    logic [15:0] paddr, tx_data, rx_data;
    logic [31:0] pwdata, prdata, rd;
    int          n_errors, comparisons, cyc;
    logic [12:0] ri[7] = '{`IDX_UPDATE_INTERVAL_MS, `IDX_OWN_NODE_NUMBER,
        `IDX_TX_SOURCE_START, `IDX_NODE_TOTAL_COUNT, `IDX_TX_REGISTER_COUNT,
        `IDX_RX_DESTINATION_START, `IDX_MODULE_CONTROL_FLAGS};
    logic [15:0] rv[7] = '{`RST_UPDATE_INTERVAL, 16'h0000, `RST_START_REG,
        `RST_NODE_TOTAL, `RST_TX_COUNT, `RST_START_REG, 16'h0000};
    logic [15:0] fw[6] = '{16'h0002, 16'h0014, 16'h0003, 16'h00A1,
        16'h00A2, 16'h00A3};

    peer_share #(.CYCLES_PER_MS(10)) DUT (
        .ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .tx_valid, .tx_ready, .tx_data,
        .tx_first, .tx_last, .rx_valid, .rx_data, .rx_first, .rx_last,
        .mac_collision, .mac_excess_collision, .other_req, .other_grant);
    peer_mac_model mac (
        .ref_clk, .tx_valid, .tx_ready, .tx_data, .tx_first, .rx_valid,
        .rx_data, .rx_first, .rx_last);

    // ========================================================================
    // clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end

    // ========================================================================
    // apb master: setup, access held until pready
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [15:0] d);
        @(posedge ref_clk);
        {psel, penable, pwrite} <= {2'b10, w};
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [12:0] i, input logic [15:0] d);
        apb(1'b1, {1'b0, i, 2'b00}, d);
    endtask
    task automatic chk(input logic [12:0] i, input logic [15:0] e,
                       input string n);
        apb(1'b0, {1'b0, i, 2'b00}, 16'h0000);
        `CHK(n, {16'h0000, e}, rd)
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ========================================================================
    // test sequence
    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, mac_collision, mac_excess_collision} = 5'h00;
        other_req = 1'b0;
        {paddr, pwdata} = 48'h0;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 7; k++) chk(ri[k], rv[k], "reset");
        $display("test reset over");
        // node two of two sends a three word slice every 4 ms
        other_req <= 1'b1;
        for (int k = 0; k < 3; k++) wr(13'd10 + 13'(k), 16'h00A1 + 16'(k));
        wr(`IDX_TX_SOURCE_START, 16'h000A);
        wr(`IDX_TX_REGISTER_COUNT, 16'h0003);
        wr(`IDX_RX_DESTINATION_START, 16'h0014);
        wr(`IDX_NODE_TOTAL_COUNT, 16'h0002);
        wr(`IDX_UPDATE_INTERVAL_MS, 16'h0004);
        wr(`IDX_OWN_NODE_NUMBER, 16'h0002);
        wr(`IDX_MODULE_CONTROL_FLAGS, 16'h0020);
        for (int k = 0; k < 400 && mac.got.size() < 18; k++) @(posedge ref_clk);
        wr(`IDX_MODULE_CONTROL_FLAGS, 16'h0000);
        `CHK("gap", 40, mac.starts[2] - mac.starts[1])
        for (int k = 0; k < 6; k++) `CHK("word", fw[k], mac.got[k])
        chk(`IDX_TX_PACKET_COUNT_A, 16'h0003, "sent");
        `CHK("grant", 1'b1, other_grant)
        $display("test transmit over");
        // listen-only node hears two peers, one unflagged
        wr(`IDX_OWN_NODE_NUMBER, 16'h0000);
        wr(`IDX_MODULE_CONTROL_FLAGS, 16'h0020);
        mac.send('{16'h0003, 16'h0064, 16'h0002, 16'h00B1, 16'h00B2});
        mac.send('{16'h0011, 16'h0066, 16'h0001, 16'h00C1});
        chk(`IDX_PEER_ACTIVE_BITMAP, 16'h0004, "active");
        chk(13'd100, 16'h00B1, "copy");
        chk(13'd101, 16'h00B2, "copy");
        chk(`IDX_TX_PACKET_COUNT_B, 16'h0002, "heard");
        repeat (200) @(posedge ref_clk);
        `CHK("sends", 3, mac.starts.size())
        chk(`IDX_PEER_ACTIVE_BITMAP, 16'h0000, "silent");
        $display("test listen over");
        // sharing off ignores peers; read only and unmapped places
        wr(`IDX_MODULE_CONTROL_FLAGS, 16'h0000);
        wr(13'd200, 16'h5555);
        mac.send('{16'h0004, 16'h00C8, 16'h0001, 16'h00D1});
        chk(13'd200, 16'h5555, "ignored");
        chk(`IDX_TX_PACKET_COUNT_B, 16'h0002, "heard");
        wr(`IDX_PEER_ACTIVE_BITMAP, 16'hFFFF);
        chk(`IDX_PEER_ACTIVE_BITMAP, 16'h0000, "read only");
        apb(1'b0, 16'hFD2C, 16'h0000);
        `CHK("unmapped", 33'h0_0000_0001, {rd, err})
        // three collisions then one excess collision
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            {mac_collision, mac_excess_collision} <= {k < 3, k == 3};
            @(posedge ref_clk);
            {mac_collision, mac_excess_collision} <= 2'b00;
        end
        chk(`IDX_COLLISION_COUNT_A, 16'h0003, "collisions");
        chk(`IDX_COLLISION_COUNT_B, 16'h0001, "excess");
        $display("test statistics over");
        close_out();
    end
endmodule

`default_nettype wire
